// *** testbench/add_imm_reg_decode_props.sv ***
`timescale 1ns/1ps
`include "add_decode_defs.vh"
module add_imm_reg_decode_props (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [31:0] rd_data,
  input wire done,
  input wire [2:0] outcome,
  input wire branch_valid,
  input wire [31:0] branch_target
);
  wire instr_wr = wr_strobe && (addr == `OFS_INSTR);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_done_lat; instr_wr |-> ##2 done; endproperty
  a_done_lat: assert property (p_done_lat) else $error("done missing after instruction write");
  property p_done_cause; done |-> $past(instr_wr, 2); endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without instruction write");
  property p_done_pulse; done && !$past(instr_wr) |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_rd_idle; !$past(rd_strobe) |-> rd_data == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_bv_done; branch_valid |-> done && outcome == `OUT_EXEC; endproperty
  a_bv_done: assert property (p_bv_done) else $error("branch without executed add");
  property p_out_hold; !done |-> $stable(outcome); endproperty
  a_out_hold: assert property (p_out_hold) else $error("outcome changed without done");
  property p_bt_hold; !branch_valid |-> $stable(branch_target); endproperty
  a_bt_hold: assert property (p_bt_hold) else $error("branch target changed without branch");
  property p_rst_quiet; $rose(rst_b) |-> !done && !branch_valid && rd_data == 32'h0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  c_exec: cover property (done && outcome == `OUT_EXEC);
  c_branch: cover property (branch_valid);
  c_unpred: cover property (done && outcome == `OUT_UNPRED);
endmodule // add_imm_reg_decode_props
bind add_imm_reg_decode add_imm_reg_decode_props add_imm_reg_decode_props_i (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
  .done(done), .outcome(outcome), .branch_valid(branch_valid), .branch_target(branch_target));

// *** testbench/add_imm_reg_decode_test.sv ***
`timescale 1ns/1ps
`include "add_decode_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin $display("[ERR] %s exp %h got %h", n, e, g); n_fail++; end end
module add_imm_reg_decode_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  wire [31:0] rd_data;
  wire done;
  wire [2:0] outcome;
  wire branch_valid;
  wire [31:0] branch_target;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rv;
  logic bv;
  logic [31:0] bt;
  add_imm_reg_decode add_imm_reg_decode_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .done(done), .outcome(outcome),
    .branch_valid(branch_valid), .branch_target(branch_target));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    rv = rd_data;
  endtask
  task chk(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    `CHK(n, e, rv)
  endtask
  // Sets control and pc, issues one instruction and waits for its result
  task run(input logic [4:0] c, input logic [31:0] pc, input logic [31:0] ins, input logic [2:0] e);
    int k;
    wr(`OFS_CTRL, {27'h0, c});
    wr(`OFS_PC, pc);
    wr(`OFS_INSTR, ins);
    k = 0;
    while (done !== 1'b1 && k < 6)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK("done", 1'b1, done)
    `CHK("outcome", e, outcome)
    bv = branch_valid;
    bt = branch_target;
  endtask
  task t_reset;
    chk(`OFS_CTRL, 32'h09, "ctrl reset");
    chk(`OFS_STATUS, 32'h0, "status reset");
    chk(8'h30, 32'h0, "unmapped");
  endtask
  task t_wide;
    wr(8'h48, 32'h10);
    wr(`OFS_STATUS, 32'hA);
    run(5'h19, 32'h0, 32'hF60273FF, `OUT_EXEC);
    chk(8'h4C, 32'h100F, "wide sum");
    chk(`OFS_STATUS, 32'hA, "wide flags");
    run(5'h19, 32'h1003, 32'hF20F1423, `OUT_EXEC);
    chk(8'h50, 32'h1123, "pc add");
    run(5'h19, 32'h1003, 32'hF2AF1423, `OUT_EXEC);
    chk(8'h50, 32'h0EDD, "pc sub");
    run(5'h19, 32'h0, 32'hF20D73FF, `OUT_SP_IMM);
    run(5'h18, 32'h0, 32'hF60273FF, `OUT_UNDEF);
    run(5'h19, 32'h0, 32'hF6027DFF, `OUT_UNPRED);
    run(5'h19, 32'h0, 32'hF6027FFF, `OUT_UNPRED);
    run(5'h18, 32'h1003, 32'hF20F1423, `OUT_UNDEF);
    run(5'h19, 32'h1003, 32'hF2AF1D23, `OUT_UNPRED);
    run(5'h19, 32'h0, 32'hF8001000, `OUT_OTHER);
    chk(8'h4C, 32'h100F, "no write");
  endtask
  task lowreg(input logic [31:0] a, input logic [31:0] b, input logic [4:0] c, input logic [3:0] f);
    wr(8'h40, a);
    wr(8'h44, b);
    run(c, 32'h0, 32'h1842, `OUT_EXEC);
    chk(8'h48, a + b, "low sum");
    rd(`OFS_STATUS);
    `CHK("low flags", f, rv[3:0])
  endtask
  task t_short;
    run(5'h09, 32'h2002, 32'h0000A5FF, `OUT_EXEC);
    chk(8'h54, 32'h23FC, "short pc add");
    lowreg(32'h7FFFFFFF, 32'h1, 5'h09, 4'h9);
    lowreg(32'hFFFFFFFF, 32'h1, 5'h09, 4'h6);
    lowreg(32'hFFFFFFFF, 32'h2, 5'h0B, 4'h6);
    wr(8'h40, 32'h3);
    wr(`OFS_COUNT, 32'h0);
    run(5'h01, 32'h0, 32'h1842, `OUT_EXEC);
    chk(8'h48, 32'h1, "cond fail reg");
    chk(`OFS_STATUS, 32'h6, "cond fail flags");
    chk(`OFS_RESULT, 32'h1, "cond fail result");
    chk(`OFS_COUNT, 32'h0, "cond fail count");
    run(5'h0B, 32'h0, 32'h1842, `OUT_EXEC);
    chk(`OFS_RESULT, 32'h5, "block sum");
    chk(`OFS_COUNT, 32'h1, "block count");
  endtask
  task t_high;
    wr(8'h64, 32'h5);
    wr(8'h68, 32'h6);
    run(5'h09, 32'h0, 32'h44D1, `OUT_EXEC);
    chk(8'h64, 32'hB, "high sum");
    run(5'h09, 32'h0, 32'h44E9, `OUT_SP_REG);
    run(5'h09, 32'h0, 32'h44D5, `OUT_SP_REG);
    run(5'h09, 32'h3000, 32'h44D7, `OUT_EXEC);
    `CHK("branch", 2'b11, {bv, bt === 32'h3006})
    chk(`OFS_STATUS, 32'h6, "branch flags");
    run(5'h0B, 32'h3000, 32'h44D7, `OUT_UNPRED);
    `CHK("no branch", 1'b0, bv)
    run(5'h0F, 32'h3000, 32'h44D7, `OUT_EXEC);
    `CHK("last slot branch", 1'b1, bv)
    run(5'h01, 32'h3000, 32'h44D7, `OUT_EXEC);
    `CHK("failed branch", 1'b0, bv)
    run(5'h09, 32'h3000, 32'h44FF, `OUT_UNPRED);
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_wide;
    t_short;
    t_high;
    test_done;
  end
endmodule // add_imm_reg_decode_test

// *** verilog/add_decode_defs.vh ***
`ifndef ADD_DECODE_DEFS_VH
`define ADD_DECODE_DEFS_VH
// Register byte offsets
`define OFS_INSTR 8'h00
`define OFS_CTRL 8'h04
`define OFS_PC 8'h08
`define OFS_STATUS 8'h0C
`define OFS_RESULT 8'h10
`define OFS_COUNT 8'h14
`define GPR_SEL 2'h1
// Control bit positions
`define CTRL_MAIN_EXT 0
`define CTRL_IN_BLOCK 1
`define CTRL_LAST_BLOCK 2
`define CTRL_COND_PASS 3
`define CTRL_WIDE 4
`define CTRL_RESET 5'h09
// Status fields
`define ST_OUT_LSB 4
`define ST_BUSY 7
`define FLAGS_RESET 4'h0
// Outcome codes
`define OUT_EXEC 3'h0
`define OUT_UNDEF 3'h1
`define OUT_UNPRED 3'h2
`define OUT_SP_IMM 3'h3
`define OUT_SP_REG 3'h4
`define OUT_OTHER 3'h5
// Register indices and masks
`define IDX_SP 4'hD
`define IDX_PC 4'hF
`define ALIGN_MASK 32'hFFFFFFFC
`endif

// *** verilog/add_field_decoder.v ***
`timescale 1ns/1ps
`include "add_decode_defs.vh"
module add_field_decoder (
  input wire [31:0] instr,
  input wire wide,
  input wire main_ext,
  input wire in_block,
  input wire last_in_block,
  output reg [2:0] outcome,
  output reg [3:0] dest,
  output reg [3:0] src_a,
  output reg [3:0] src_b,
  output reg [31:0] imm32,
  output reg use_imm,
  output reg pc_rel,
  output reg sub,
  output reg setflags
);
  wire [3:0] first_src_field;
  wire [11:0] wide_imm_value;
  wire is_wide_add;
  wire is_adr_sub;
  wire [3:0] dn;
  assign first_src_field = instr[19:16];
  assign wide_imm_value = {instr[26], instr[14:12], instr[7:0]};
  assign is_wide_add = (instr[31:27] == 5'h1E) && (instr[25:20] == 6'h20) && !instr[15];
  assign is_adr_sub = (instr[31:27] == 5'h1E) && (instr[25:16] == 10'h2AF) && !instr[15];
  assign dn = {instr[7], instr[2:0]};
  always @*
  begin
    outcome = `OUT_OTHER;
    dest = 4'h0;
    src_a = 4'h0;
    src_b = 4'h0;
    imm32 = 32'h00000000;
    use_imm = 1'b0;
    pc_rel = 1'b0;
    sub = 1'b0;
    setflags = 1'b0;
    if (wide)
    begin
      if (is_wide_add || is_adr_sub)
      begin
        dest = instr[11:8];
        imm32 = {20'h00000, wide_imm_value};
        use_imm = 1'b1;
        if (is_adr_sub || first_src_field == `IDX_PC)
        begin
          pc_rel = 1'b1;
          sub = is_adr_sub;
          if (!main_ext)
            outcome = `OUT_UNDEF;
          else if (dest == `IDX_SP || dest == `IDX_PC)
            outcome = `OUT_UNPRED;
          else
            outcome = `OUT_EXEC;
        end
        else if (first_src_field == `IDX_SP)
          outcome = `OUT_SP_IMM;
        else if (!main_ext)
          outcome = `OUT_UNDEF;
        else if (dest == `IDX_SP || dest == `IDX_PC)
          outcome = `OUT_UNPRED;
        else
        begin
          src_a = first_src_field;
          outcome = `OUT_EXEC;
        end
      end
    end
    else if (instr[15:11] == 5'h14)
    begin
      dest = {1'b0, instr[10:8]};
      imm32 = {22'h000000, instr[7:0], 2'h0};
      use_imm = 1'b1;
      pc_rel = 1'b1;
      outcome = `OUT_EXEC;
    end
    else if (instr[15:9] == 7'h0C)
    begin
      dest = {1'b0, instr[2:0]};
      src_a = {1'b0, instr[5:3]};
      src_b = {1'b0, instr[8:6]};
      setflags = !in_block;
      outcome = `OUT_EXEC;
    end
    else if (instr[15:8] == 8'h44)
    begin
      dest = dn;
      src_a = dn;
      src_b = instr[6:3];
      if (dn == `IDX_SP || instr[6:3] == `IDX_SP)
        outcome = `OUT_SP_REG;
      else if (dn == `IDX_PC && in_block && !last_in_block)
        outcome = `OUT_UNPRED;
      else if (dn == `IDX_PC && instr[6:3] == `IDX_PC)
        outcome = `OUT_UNPRED;
      else
        outcome = `OUT_EXEC;
    end
  end
endmodule // add_field_decoder

// *** verilog/add_flag_unit.v ***
`timescale 1ns/1ps
`include "add_decode_defs.vh"
module add_flag_unit (
  input wire [31:0] op_a,
  input wire [31:0] op_b,
  input wire sub,
  output wire [31:0] sum,
  output wire [3:0] flags
);
  wire [31:0] b_eff;
  wire [32:0] full;
  wire ovf;
  // Subtract as a plus not b plus one
  assign b_eff = sub ? ~op_b : op_b;
  assign full = {1'b0, op_a} + {1'b0, b_eff} + {32'h00000000, sub};
  assign sum = full[31:0];
  assign ovf = (op_a[31] == b_eff[31]) && (sum[31] != op_a[31]);
  // Flags N Z C V
  assign flags = {sum[31], (sum == 32'h00000000), full[32], ovf};
endmodule // add_flag_unit

// *** verilog/add_imm_reg_decode.v ***
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "add_decode_defs.vh"
// Overview of operation
// - A wide immediate add whose first source is the program counter runs as an address-to-register add.
// - A wide immediate add whose first source is the stack pointer is handed to the stack-pointer decoder.
// - The wide immediate add, unless its first source is the stack pointer, is undefined without the main extension and decodes normally with it.
// - The wide immediate is the top bit, middle field and low field zero-extended, and never sets flags.
// - A wide immediate add writing register 13 or 15 is unpredictable.
// - The immediate add sums source and immediate with carry-in zero and leaves N, Z, C, V unchanged.
// - The short pc-relative add writes aligned pc plus the 8-bit field times four.
// - The wide pc-relative add writes aligned pc plus the 12-bit immediate.
// - One wide address form adds the 12-bit magnitude to aligned pc and the other subtracts it.
// - The short low-register add uses three 3-bit fields, no shift, and sets flags only outside a block.
// - The short high-register add joins the high bit, never sets flags and routes index 13 elsewhere.
// - Writing register 15 inside a conditional block before its last slot is unpredictable.
// - Register 15 as both destination and second source is unpredictable.
// - A register add writing register 15 makes a branch target and leaves flags alone.
module add_imm_reg_decode (
  input wire clk,
  input wire rst_b,
  input wire [7:0] addr,
  input wire [31:0] wr_data,
  input wire wr_strobe,
  input wire rd_strobe,
  output reg [31:0] rd_data,
  output reg done,
  output reg [2:0] outcome,
  output reg branch_valid,
  output reg [31:0] branch_target
);
  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] instr_r;
  reg [4:0] ctrl_r;
  reg [31:0] pc_r;
  reg [3:0] app_status_word;
  reg [31:0] result_r;
  reg [31:0] count_r;
  wire [31:0] gpr_r [0:15];
  reg [31:0] rd_mux;
  reg [31:0] base_val;
  reg [31:0] addend_val;

  wire [2:0] dec_outcome;
  wire [3:0] dec_dest;
  wire [3:0] dec_src_a;
  wire [3:0] dec_src_b;
  wire [31:0] dec_imm;
  wire dec_use_imm;
  wire dec_pc_rel;
  wire dec_sub;
  wire dec_setflags;
  wire [31:0] op_a;
  wire [31:0] op_b;
  wire [31:0] sum;
  wire [3:0] sum_flags;
  wire executing;
  wire commit;
  wire commit_reg;
  wire commit_branch;
  wire bus_wr_gpr;
  wire [3:0] bus_gpr_idx;
  wire wr_instr;
  wire wr_ctrl;
  wire wr_pc;
  wire wr_status;
  wire wr_count;
  wire [15:0] exec_hit;
  wire [15:0] bus_hit;

  add_field_decoder u_decoder (
    .instr(instr_r),
    .wide(ctrl_r[`CTRL_WIDE]),
    .main_ext(ctrl_r[`CTRL_MAIN_EXT]),
    .in_block(ctrl_r[`CTRL_IN_BLOCK]),
    .last_in_block(ctrl_r[`CTRL_LAST_BLOCK]),
    .outcome(dec_outcome),
    .dest(dec_dest),
    .src_a(dec_src_a),
    .src_b(dec_src_b),
    .imm32(dec_imm),
    .use_imm(dec_use_imm),
    .pc_rel(dec_pc_rel),
    .sub(dec_sub),
    .setflags(dec_setflags)
  );

  add_flag_unit u_adder (
    .op_a(op_a),
    .op_b(op_b),
    .sub(dec_sub),
    .sum(sum),
    .flags(sum_flags)
  );

  // Operand selection
  always @*
  begin
    base_val = gpr_r[dec_src_a];
    if (dec_pc_rel)
    begin
      base_val = pc_r & `ALIGN_MASK;
    end
    else if (dec_src_a == `IDX_PC)
    begin
      base_val = pc_r;
    end
  end

  always @*
  begin
    addend_val = gpr_r[dec_src_b];
    if (dec_use_imm)
    begin
      addend_val = dec_imm;
    end
    else if (dec_src_b == `IDX_PC)
    begin
      addend_val = pc_r;
    end
  end

  assign op_a = base_val;
  assign op_b = addend_val;

  // Commit qualification
  assign executing = (state_r == ST_EXEC);
  assign commit = executing && (dec_outcome == `OUT_EXEC) && ctrl_r[`CTRL_COND_PASS];
  assign commit_branch = commit && (dec_dest == `IDX_PC);
  assign commit_reg = commit && (dec_dest != `IDX_PC);
  assign bus_wr_gpr = wr_strobe && (addr[7:6] == `GPR_SEL);
  assign bus_gpr_idx = addr[5:2];
  assign wr_instr = wr_strobe && (addr == `OFS_INSTR);
  assign wr_ctrl = wr_strobe && (addr == `OFS_CTRL);
  assign wr_pc = wr_strobe && (addr == `OFS_PC);
  assign wr_status = wr_strobe && (addr == `OFS_STATUS);
  assign wr_count = wr_strobe && (addr == `OFS_COUNT);
  assign exec_hit = commit_reg ? (16'h0001 << dec_dest) : 16'h0000;
  assign bus_hit = bus_wr_gpr ? (16'h0001 << bus_gpr_idx) : 16'h0000;

  // Execution sequencer
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (wr_instr)
          state_nxt = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (!wr_instr)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Software registers
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      instr_r <= 32'h00000000;
    end
    else if (wr_instr)
    begin
      instr_r <= wr_data;
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl_r <= wr_data[4:0];
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pc_r <= 32'h00000000;
    end
    else if (wr_pc)
    begin
      pc_r <= wr_data;
    end
  end

  // Condition flags
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      app_status_word <= `FLAGS_RESET;
    else if (commit_reg && dec_setflags)
      app_status_word <= sum_flags;
    else if (wr_status)
      app_status_word <= wr_data[3:0];
  end

  // Last result and executed count
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_r <= 32'h00000000;
    end
    else if (commit)
    begin
      result_r <= sum;
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_r <= 32'h00000000;
    end
    else if (commit)
    begin
      count_r <= count_r + 32'h00000001;
    end
    else if (wr_count)
    begin
      count_r <= 32'h00000000;
    end
  end

  // General registers, execution write over software write
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : gpr_entry
      reg [31:0] entry_r;
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          entry_r <= 32'h00000000;
        end
        else if (exec_hit[gi])
        begin
          entry_r <= sum;
        end
        else if (bus_hit[gi])
        begin
          entry_r <= wr_data;
        end
      end
      assign gpr_r[gi] = entry_r;
    end
  endgenerate

  // Completion outputs
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
      outcome <= `OUT_EXEC;
    end
    else
    begin
      done <= executing;
      if (executing)
      begin
        outcome <= dec_outcome;
      end
    end
  end

  // Branch outputs
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      branch_valid <= 1'b0;
      branch_target <= 32'h00000000;
    end
    else
    begin
      branch_valid <= commit_branch;
      if (commit_branch)
      begin
        branch_target <= sum;
      end
    end
  end

  // Read path
  always @*
  begin
    rd_mux = 32'h00000000;
    if (addr[7:6] == `GPR_SEL)
      rd_mux = gpr_r[addr[5:2]];
    else
    begin
      case (addr)
        `OFS_INSTR:
          rd_mux = instr_r;
        `OFS_CTRL:
          rd_mux = {27'h0000000, ctrl_r};
        `OFS_PC:
          rd_mux = pc_r;
        `OFS_STATUS:
          rd_mux = {24'h000000, executing, outcome, app_status_word};
        `OFS_RESULT:
          rd_mux = result_r;
        `OFS_COUNT:
          rd_mux = count_r;
        default:
          rd_mux = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= 32'h00000000;
    else if (rd_strobe)
      rd_data <= rd_mux;
    else
      rd_data <= 32'h00000000;
  end
endmodule // add_imm_reg_decode
